//--- src/sfr_read_engine.sv
// Multi-lane read command engine of a serial NOR flash with an APB register port.
//
// How it works
// - Dual output read: command and 3-byte address on lane 0, 8 dummy clocks, data 2 bits per clock.
// - Dual address/data read: address 2 bits per clock, 4 dummy clocks, data 2 bits per clock.
// - Quad output read: command and address on lane 0, 8 dummy clocks, data 4 bits per clock.
// - Quad address/data read: address 4 bits per clock, 6 dummy clocks with configuration bits 7 and 6 at zero, data 4 bits per clock.
// - The quad address/data read is also taken in quad command mode with the same phases.
// - Address bits are taken on rising serial clock edges and data change on falling ones.
// - Reads start at any byte address and the address steps by one per byte sent.
// - Past the highest array location the address wraps to zero and data keep coming.
// - Raising chip select ends the read and the lanes stop being driven.
// - While a program, erase or status write runs, every read command is refused harmlessly.
// - Opcode E7h is a quad address/data read with 4 dummy clocks, single-line mode only.
// - The EBh quad address/data dummy count follows configuration bits 7 and 6; E7h keeps its 4.
`timescale 1ns/1ns
`default_nettype none
`include "sfr_map.svh"
module sfr_read_engine (
  // Clock and reset.
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave.
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial link pins.
  input  wire logic        cs_n,
  input  wire logic        sclk,
  input  wire logic [3:0]  lane_in,
  output logic      [3:0]  lane_out,
  output logic      [3:0]  lane_oe,
  // Array read port and write engine status.
  output logic      [23:0] array_addr,
  input  wire logic [7:0]  array_data,
  input  wire logic        write_busy
);
  import sfr_pkg::*;

  // Pin synchronisers; the sclk chain has a third stage for edge detection.
  logic [1:0] cs_sy;
  logic [2:0] ck_sy;
  logic [3:0] ln_s1, ln_s2;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cs_sy <= 2'h3;
      ck_sy <= 3'h0;
      ln_s1 <= 4'h0;
      ln_s2 <= 4'h0;
    end else begin
      cs_sy <= {cs_sy[0], cs_n};
      ck_sy <= {ck_sy[1:0], sclk};
      ln_s1 <= lane_in;
      ln_s2 <= ln_s1;
    end
  end

  logic cs_q, rise, fall;
  assign cs_q = cs_sy[1];
  assign rise = ck_sy[1] & ~ck_sy[2];
  assign fall = ~ck_sy[1] & ck_sy[2];
  // Register file state.
  logic [31:0] cfg_reg, cfg_next, prdata_reg, prdata_next;
  logic        rej_reg, rej_next, rej_set;
  logic        quad_lane_enable_bit, quad_command_mode;
  logic [1:0]  dc_cfg;
  assign quad_lane_enable_bit = cfg_reg[`SFR_CFG_QE];
  assign quad_command_mode    = cfg_reg[`SFR_CFG_QPI];
  assign dc_cfg = {cfg_reg[`SFR_CFG_DC_MSB], cfg_reg[`SFR_CFG_DC_LSB]};
  // Link state.
  sfr_state_e  state_reg, state_next;
  sfr_kind_e   kind_reg, kind_next;
  logic [5:0]  cnt_reg, cnt_next;
  logic [7:0]  sh_reg, sh_next, cmd_byte;
  logic [23:0] addr_reg, addr_next;
  logic [3:0]  out_reg, out_next, oe_reg, oe_next;
  // Lanes carrying address bits for a command.
  function automatic logic [2:0] addr_width(input sfr_kind_e k);
    case (k)
      K_DUAL_IO:               addr_width = 3'h2;
      K_QUAD_IO, K_QUAD_SHORT: addr_width = 3'h4;
      default:                 addr_width = 3'h1;
    endcase
  endfunction
  // Lanes carrying data bits for a command.
  function automatic logic [2:0] data_width(input sfr_kind_e k);
    case (k)
      K_DUAL_OUT, K_DUAL_IO: data_width = 3'h2;
      default:               data_width = 3'h4;
    endcase
  endfunction
  // Dummy clocks for a command.
  function automatic logic [5:0] dummy_clks(input sfr_kind_e k, input logic [1:0] dc);
    case (k)
      K_QUAD_IO: begin
        case (dc)
          2'h0:    dummy_clks = `SFR_DC00;
          2'h1:    dummy_clks = `SFR_DC01;
          2'h2:    dummy_clks = `SFR_DC10;
          default: dummy_clks = `SFR_DC11;
        endcase
      end
      K_QUAD_SHORT: dummy_clks = `SFR_DUMMY_SHORT;
      K_DUAL_IO:    dummy_clks = `SFR_DUMMY_DUAL_IO;
      default:      dummy_clks = `SFR_DUMMY_LONG;
    endcase
  endfunction
  // Command byte completed by the lanes at this rising edge, MSB first.
  assign cmd_byte = quad_command_mode ? {sh_reg[3:0], ln_s2} : {sh_reg[6:0], ln_s2[0]};
  // Link sequencer: command, address, dummy and data phases.
  always_comb begin
    sfr_kind_e k;
    logic [2:0] w;
    k = K_NONE;
    w = data_width(kind_reg);
    state_next = state_reg;
    kind_next  = kind_reg;
    cnt_next   = cnt_reg;
    sh_next    = sh_reg;
    addr_next  = addr_reg;
    out_next   = out_reg;
    oe_next    = oe_reg;
    rej_set    = 1'b0;
    if (cs_q) begin
      state_next = ST_IDLE;
      oe_next    = 4'h0;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          state_next = ST_CMD;
          sh_next    = 8'h00;
          cnt_next   = (quad_command_mode ? `SFR_CMD_QPI_CLKS : `SFR_CMD_SPI_CLKS) - 6'h01;
        end
        ST_CMD: begin
          if (rise) begin
            sh_next = cmd_byte;
            if (cnt_reg != 6'h00) begin
              cnt_next = cnt_reg - 6'h01;
            end else begin
              // Single-line quad commands need the quad enable bit; quad mode knows one read only and does not check that bit.
              if (quad_command_mode) begin
                if (cmd_byte == `SFR_OP_QUAD_IO) k = K_QUAD_IO;
              end else begin
                case (cmd_byte)
                  `SFR_OP_DUAL_OUT: k = K_DUAL_OUT;
                  `SFR_OP_DUAL_IO:  k = K_DUAL_IO;
                  `SFR_OP_QUAD_OUT: k = quad_lane_enable_bit ? K_QUAD_OUT : K_NONE;
                  `SFR_OP_QUAD_IO:  k = quad_lane_enable_bit ? K_QUAD_IO : K_NONE;
                  `SFR_OP_QUAD_SHORT: k = quad_lane_enable_bit ? K_QUAD_SHORT : K_NONE;
                  default:          k = K_NONE;
                endcase
              end
              kind_next = k;
              addr_next = 24'h00_0000;
              if (k == K_NONE || write_busy) begin
                // A busy refusal leaves the write engine alone and is flagged to software.
                state_next = ST_REJECT;
                rej_set    = write_busy && (k != K_NONE);
              end else begin
                state_next = ST_ADDR;
                cnt_next   = 6'(`SFR_ADDR_BITS / addr_width(k)) - 6'h01;
              end
            end
          end
        end
        ST_ADDR: begin
          if (rise) begin
            // Address bits enter on rising edges, MSB first.
            case (addr_width(kind_reg))
              3'h1:    addr_next = {addr_reg[22:0], ln_s2[0]};
              3'h2:    addr_next = {addr_reg[21:0], ln_s2[1:0]};
              default: addr_next = {addr_reg[19:0], ln_s2};
            endcase
            if (cnt_reg == 6'h00) begin
              state_next = ST_DUMMY;
              cnt_next   = dummy_clks(kind_reg, dc_cfg) - 6'h01;
            end else begin
              cnt_next = cnt_reg - 6'h01;
            end
          end
        end
        ST_DUMMY: begin
          // Lanes stay released so the host may drive its mode byte.
          if (rise) begin
            if (cnt_reg == 6'h00) begin
              state_next = ST_DATA;
            end else begin
              cnt_next = cnt_reg - 6'h01;
            end
          end
        end
        ST_DATA: begin
          if (fall) begin
            oe_next = (w == 3'h2) ? 4'h3 : 4'hf;
            if (cnt_reg == 6'h00) begin
              // Take the fetched byte and move the address on; the mask wraps at the top.
              sh_next   = array_data << w;
              out_next  = (w == 3'h2) ? {2'h0, array_data[7:6]} : array_data[7:4];
              addr_next = (addr_reg + 24'h00_0001) & `SFR_ARRAY_MASK;
              cnt_next  = 6'(`SFR_BYTE_BITS / w) - 6'h01;
            end else begin
              sh_next  = sh_reg << w;
              out_next = (w == 3'h2) ? {2'h0, sh_reg[7:6]} : sh_reg[7:4];
              cnt_next = cnt_reg - 6'h01;
            end
          end
        end
        ST_REJECT: state_next = ST_REJECT;
        default:   state_next = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
      kind_reg  <= K_NONE;
      cnt_reg   <= 6'h00;
      sh_reg    <= 8'h00;
      addr_reg  <= 24'h00_0000;
      out_reg   <= 4'h0;
      oe_reg    <= 4'h0;
    end else begin
      state_reg <= state_next;
      kind_reg  <= kind_next;
      cnt_reg   <= cnt_next;
      sh_reg    <= sh_next;
      addr_reg  <= addr_next;
      out_reg   <= out_next;
      oe_reg    <= oe_next;
    end
  end

  assign lane_out   = out_reg;
  assign lane_oe    = oe_reg;
  assign array_addr = addr_reg;
  // APB slave: zero wait states, read data captured in the setup cycle.
  logic setup, access, hit;
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign hit    = (paddr == `SFR_CFG_OFS) || (paddr == `SFR_STATUS_OFS) ||
                  (paddr == `SFR_ADDR_OFS);
  assign pready  = 1'b1;
  assign pslverr = access & ~hit;
  assign prdata  = prdata_reg;
  // Register next values; a new refusal wins over a same-cycle clear.
  always_comb begin
    cfg_next    = cfg_reg;
    rej_next    = rej_reg;
    prdata_next = prdata_reg;
    if (access && pwrite && paddr == `SFR_CFG_OFS) begin
      cfg_next = pwdata & `SFR_CFG_WMASK;
    end
    if (access && pwrite && paddr == `SFR_STATUS_OFS && pwdata[`SFR_ST_REJ]) begin
      rej_next = 1'b0;
    end
    if (rej_set) begin
      rej_next = 1'b1;
    end
    if (setup) begin
      prdata_next = 32'h0000_0000;
      case (paddr)
        `SFR_CFG_OFS: prdata_next = cfg_reg;
        `SFR_STATUS_OFS: begin
          prdata_next[`SFR_ST_REJ]  = rej_reg;
          prdata_next[`SFR_ST_ACT]  = (state_reg != ST_IDLE);
          prdata_next[`SFR_ST_BUSY] = write_busy;
        end
        `SFR_ADDR_OFS: prdata_next = {8'h00, addr_reg};
        default: prdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg    <= `SFR_CFG_RST;
      rej_reg    <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      cfg_reg    <= cfg_next;
      rej_reg    <= rej_next;
      prdata_reg <= prdata_next;
    end
  end
  // Checks on the link sequencer.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_cs_release_quiet: assert property (cs_q |=> lane_oe == 4'h0)
    else $error("lanes still driven after chip select rose");
  a_busy_refuses: assert property (
    state_reg == ST_CMD && rise && cnt_reg == 6'h00 && write_busy && !cs_q
    |=> state_reg == ST_REJECT)
    else $error("read accepted while write busy");
  a_reject_silent: assert property (state_reg == ST_REJECT |-> lane_oe == 4'h0)
    else $error("refused read drives lanes");
  a_lane_on_fall: assert property (!fall |=> $stable(lane_out))
    else $error("lane data changed without falling clock");
  a_addr_step: assert property (
    state_reg == ST_DATA && fall && cnt_reg == 6'h00 && !cs_q
    |=> array_addr == (($past(array_addr) + 24'h00_0001) & `SFR_ARRAY_MASK))
    else $error("address did not step by one");
  a_addr_wrap: assert property (
    state_reg == ST_DATA && fall && cnt_reg == 6'h00 && !cs_q &&
    array_addr == `SFR_ARRAY_MASK |=> array_addr == 24'h00_0000)
    else $error("address did not wrap to zero");
  a_dual_two_lanes: assert property (
    (kind_reg == K_DUAL_OUT || kind_reg == K_DUAL_IO) && state_reg == ST_DATA
    |-> (lane_oe & 4'hc) == 4'h0)
    else $error("dual read drives upper lanes");
  a_short_dummy: assert property (
    state_reg == ST_ADDR && kind_reg == K_QUAD_SHORT && rise && cnt_reg == 6'h00 && !cs_q
    |=> state_reg == ST_DUMMY && cnt_reg == `SFR_DUMMY_SHORT - 6'h01)
    else $error("short quad read dummy count wrong");
  a_dc_dummy: assert property (
    state_reg == ST_ADDR && kind_reg == K_QUAD_IO && rise && cnt_reg == 6'h00 &&
    dc_cfg == 2'h1 && !cs_q |=> cnt_reg == `SFR_DC01 - 6'h01)
    else $error("quad read ignores dummy configuration");
  a_qpi_cmd_len: assert property (
    state_reg == ST_IDLE && !cs_q && quad_command_mode
    |=> state_reg == ST_CMD && cnt_reg == `SFR_CMD_QPI_CLKS - 6'h01)
    else $error("quad mode command length wrong");
  c_dual_io_data: cover property (state_reg == ST_DATA && kind_reg == K_DUAL_IO && fall);
  c_quad_short_data: cover property (state_reg == ST_DATA && kind_reg == K_QUAD_SHORT && fall);
  c_busy_reject: cover property (rej_set);
  c_wrap: cover property (state_reg == ST_DATA && array_addr == 24'h00_0000 && fall);
endmodule
`default_nettype wire

//--- src/sfr_map.svh
// Register offsets, field positions, opcodes and phase counts of the flash read engine.
`ifndef SFR_MAP_SVH
`define SFR_MAP_SVH
// Register byte addresses on the APB slave.
`define SFR_CFG_OFS      12'h000
`define SFR_STATUS_OFS   12'h004
`define SFR_ADDR_OFS     12'h008
// Configuration fields and reset value.
`define SFR_CFG_QE       0
`define SFR_CFG_QPI      1
`define SFR_CFG_DC_LSB   6
`define SFR_CFG_DC_MSB   7
`define SFR_CFG_WMASK    32'h0000_00c3
`define SFR_CFG_RST      32'h0000_0000
// Status fields.
`define SFR_ST_REJ       0
`define SFR_ST_ACT       1
`define SFR_ST_BUSY      2
// Read opcodes.
`define SFR_OP_DUAL_OUT  8'h3b
`define SFR_OP_DUAL_IO   8'hbb
`define SFR_OP_QUAD_OUT  8'h6b
`define SFR_OP_QUAD_IO   8'heb
`define SFR_OP_QUAD_SHORT 8'he7
// Phase lengths in serial clocks.
`define SFR_CMD_SPI_CLKS 6'h08
`define SFR_CMD_QPI_CLKS 6'h02
`define SFR_DUMMY_LONG   6'h08
`define SFR_DUMMY_DUAL_IO 6'h04
`define SFR_DUMMY_SHORT  6'h04
`define SFR_DC00         6'h06
`define SFR_DC01         6'h04
`define SFR_DC10         6'h08
`define SFR_DC11         6'h0a
// Array geometry.
`define SFR_ADDR_BITS    24
`define SFR_BYTE_BITS    8
`define SFR_ARRAY_MASK   24'h3f_ffff
`endif

//--- src/sfr_pkg.sv
// Types shared by the flash read engine.
package sfr_pkg;
  typedef enum {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY, ST_DATA, ST_REJECT} sfr_state_e;
  typedef enum {K_NONE, K_DUAL_OUT, K_DUAL_IO, K_QUAD_OUT, K_QUAD_IO, K_QUAD_SHORT} sfr_kind_e;
endpackage

//--- dv/sfr_host_model.sv
// Host flash controller model that frames read commands on the serial link.
`timescale 1ns/1ns
`default_nettype none
module sfr_host_model (
  // Clock.
  input  wire logic       pclk,
  // Link pins.
  output logic            cs_n,
  output logic            sclk,
  output logic      [3:0] lane_in,
  input  wire logic [3:0] lane_out,
  input  wire logic [3:0] lane_oe,
  // High once the device drove a lane in the current frame.
  output logic            oe_seen
);
  logic [3:0] drv;
  logic [3:0] drv_en;
  logic [3:0] flt;

  // Undriven lanes toggle each clock, so stale data can never pass for a match.
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & ((drv_en & drv) | (~drv_en & flt)));

  // Idle link: select high and the serial clock parked low between frames.
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    drv = 4'h0;
    drv_en = 4'h0;
    flt = 4'h5;
    oe_seen = 1'b0;
  end

  // Floating pattern, and a watch on the device's lane enables.
  always @(posedge pclk) begin
    flt <= ~flt;
    if (!cs_n && |lane_oe) begin
      oe_seen <= 1'b1;
    end
  end

  function automatic logic [3:0] msk(input int w);
    return 4'hf >> (4 - w);
  endfunction

  // One serial clock; device lanes are read at the end of the high half.
  task automatic tick(input logic [3:0] v, input logic [3:0] en, output logic [3:0] got);
    drv <= v;
    drv_en <= en;
    repeat (4) @(posedge pclk);
    sclk <= 1'b1;
    repeat (4) @(posedge pclk);
    got = lane_in;
    sclk <= 1'b0;
  endtask

  // Command, address, dummy and three data bytes; cw, aw and dw are lanes per phase.
  task automatic frame(input logic [7:0] op, input int cw, input logic [23:0] adr,
                       input int aw, input int dm, input int dw, output logic [23:0] dat);
    logic [3:0]  got;
    logic [31:0] sh;
    dat = 24'h0;
    oe_seen <= 1'b0;
    cs_n <= 1'b0;
    repeat (4) @(posedge pclk);
    sh = {op, 24'h0};
    for (int i = 0; i < 8 / cw; i++) begin
      tick(sh[31:28] >> (4 - cw), msk(cw), got);
      sh = sh << cw;
    end
    sh = {adr, 8'h0};
    for (int i = 0; i < 24 / aw; i++) begin
      tick(sh[31:28] >> (4 - aw), msk(aw), got);
      sh = sh << aw;
    end
    // Mode and dummy clocks drive the address lanes low; any other lane floats with the toggling pattern.
    for (int i = 0; i < dm; i++) begin
      tick(4'h0, msk(aw), got);
    end
    for (int i = 0; i < 24 / dw; i++) begin
      tick(4'h0, 4'h0, got);
      dat = (dat << dw) | 24'(got & msk(dw));
    end
    cs_n <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask
endmodule
`default_nettype wire

//--- dv/sfr_read_engine_test.sv
// Self-checking bench of the flash read engine with a host model on the link.
`timescale 1ns/1ns
`default_nettype none
`include "sfr_map.svh"
module sfr_read_engine_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic        cs_n, sclk, write_busy, oe_seen;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [3:0]  lane_in, lane_out, lane_oe;
  logic [23:0] array_addr, a, got;
  logic [7:0]  array_data;
  int          num_errors, num_checks;

  sfr_read_engine dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .cs_n, .sclk, .lane_in, .lane_out, .lane_oe, .array_addr,
    .array_data, .write_busy);
  sfr_host_model host (.pclk, .cs_n, .sclk, .lane_in, .lane_out, .lane_oe, .oe_seen);

  // 50 MHz system clock.
  always #10 pclk = ~pclk;

  function automatic logic [7:0] mem(input logic [23:0] x);
    return x[7:0] ^ x[15:8] ^ x[23:16] ^ 8'h5a;
  endfunction

  // Array model answers one clock after the address moves, well inside its allowance.
  always @(posedge pclk) begin
    array_data <= mem(array_addr);
  end

  // Three bytes from x on, wrapping past the top of the array.
  function automatic logic [23:0] exp3(input logic [23:0] x);
    return {mem(x), mem((x + 24'h1) & `SFR_ARRAY_MASK), mem((x + 24'h2) & `SFR_ARRAY_MASK)};
  endfunction

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int dc_of(input logic [1:0] c);
    case (c)
      2'h0: return int'(`SFR_DC00);
      2'h1: return int'(`SFR_DC01);
      2'h2: return int'(`SFR_DC10);
      default: return int'(`SFR_DC11);
    endcase
  endfunction

  task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic chk_data(input logic [23:0] g, input logic [23:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // One APB transfer; the request holds until pready is seen high.
  // Only the watchdog ends a wait that never sees pready.
  task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= ad;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  // One read frame at address a; a refused frame leaves every lane undriven.
  task automatic rd_frame(input logic [7:0] op, input int cw, input int aw, input int dm,
                          input int dw, input logic good);
    host.frame(op, cw, a, aw, dm, dw, got);
    chk_word({31'h0, oe_seen}, {31'h0, good});
    if (good) begin
      chk_data(got, exp3(a));
      // Three bytes went out, so the internal address sits three past the start.
      apb(1'b0, `SFR_ADDR_OFS, 32'h0);
      chk_word(rd, {8'h00, (a + 24'h00_0003) & `SFR_ARRAY_MASK});
    end
    chk_word({28'h0, lane_oe}, 32'h0);
  endtask

  task automatic results();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog well beyond the expected run of some ten thousand clocks.
  initial begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    results();
  end

  // Main sequence: registers, refusals, every read kind and dummy setting, busy refusal.
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    write_busy = 1'b0;
    num_errors = 0;
    num_checks = 0;
    seed = 32'h0000_003a;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `SFR_CFG_OFS, 32'h0);
    chk_word(rd, `SFR_CFG_RST);
    apb(1'b0, 12'h00c, 32'h0);
    chk_word({rd[30:0], err}, 32'h1);
    apb(1'b1, `SFR_CFG_OFS, 32'hffff_ffff);
    apb(1'b0, `SFR_CFG_OFS, 32'h0);
    chk_word(rd, `SFR_CFG_WMASK);
    apb(1'b1, `SFR_CFG_OFS, 32'h0);
    a = 24'(rnd()) & `SFR_ARRAY_MASK;
    rd_frame(`SFR_OP_QUAD_OUT, 1, 1, 8, 4, 1'b0);
    rd_frame(`SFR_OP_QUAD_IO, 1, 4, 6, 4, 1'b0);
    rd_frame(8'h5a, 1, 1, 8, 2, 1'b0);
    for (int i = 0; i < 4; i++) begin
      a = (i == 0) ? 24'h3f_fffe : 24'(rnd()) & `SFR_ARRAY_MASK;
      apb(1'b1, `SFR_CFG_OFS, {24'h0, i[1:0], 6'h01});
      rd_frame(`SFR_OP_DUAL_OUT, 1, 1, 8, 2, 1'b1);
      rd_frame(`SFR_OP_DUAL_IO, 1, 2, 4, 2, 1'b1);
      rd_frame(`SFR_OP_QUAD_OUT, 1, 1, 8, 4, 1'b1);
      rd_frame(`SFR_OP_QUAD_SHORT, 1, 4, 4, 4, 1'b1);
      rd_frame(`SFR_OP_QUAD_IO, 1, 4, dc_of(i[1:0]), 4, 1'b1);
      apb(1'b1, `SFR_CFG_OFS, {24'h0, i[1:0], 6'h03});
      rd_frame(`SFR_OP_QUAD_IO, 4, 4, dc_of(i[1:0]), 4, 1'b1);
      rd_frame(`SFR_OP_QUAD_SHORT, 4, 4, 4, 4, 1'b0);
    end
    apb(1'b1, `SFR_CFG_OFS, 32'h1);
    write_busy <= 1'b1;
    rd_frame(`SFR_OP_DUAL_OUT, 1, 1, 8, 2, 1'b0);
    apb(1'b0, `SFR_STATUS_OFS, 32'h0);
    chk_word(rd, 32'h5);
    write_busy <= 1'b0;
    apb(1'b1, `SFR_STATUS_OFS, 32'h1);
    apb(1'b0, `SFR_STATUS_OFS, 32'h0);
    chk_word(rd, 32'h0);
    rd_frame(`SFR_OP_DUAL_OUT, 1, 1, 8, 2, 1'b1);
    results();
  end
endmodule
`default_nettype wire
